//--- hdl/fah_feature_handler.v
// Set/get handling of arbitration, power and range features
//
// How it works
// RQ1: Feature 01h sets arbitration weights and burst for queue arbitration.
// RQ2: Set takes attributes from dword 11; get returns them in dword 0.
// RQ3: Bits 31:24 give high-class commands per round, value plus one.
// RQ4: Bits 23:16 give medium-class commands per round, zero-based.
// RQ5: Bits 15:08 give low-class commands per round, zero-based.
// RQ6: Bits 02:00 cap per-queue burst at two to the n; 111b none.
// RQ7: Feature 02h moves the controller to the power state in bits 04:00.
// RQ8: Host requests only advertised power states; others are undefined.
// RQ9: Optional feature 03h reports types and attributes of namespace ranges.
// RQ10: Range buffer is 4096 contiguous bytes in host memory.
// RQ11: Range get returns count in dword 0 and whole structure to host.
// RQ12: Bits 05:00 give zero-based number of range entries.
// RQ13: Structure is consecutive 64-byte entries, at most 64 of them.
// RQ14: Whoever fills the structure keeps the ranges from overlapping.
// RQ15: Every unused entry reads as all zero bytes.
// RQ16: New settings apply to commands queued after a set completes.
// RQ17: Reserved attribute bits ignored on set and returned zero on get.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps

`include "fah_map.vh"

module fah_feature_handler (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // Register port
    input wire [3:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    // Settings seen by the arbiter and power logic
    output reg [8:0] high_class_count_o,
    output reg [8:0] medium_class_count_o,
    output reg [8:0] low_class_count_o,
    output reg [2:0] queue_burst_limit_o,
    output reg burst_unlimited_o,
    output reg [4:0] power_state_select_o,
    output reg power_change_o,
    // Range data streamed to the host data buffer
    output reg xfer_valid_o,
    output reg [31:0] xfer_data_o,
    output reg xfer_last_o,
    // Completion
    output reg cpl_valid_o,
    output reg [31:0] cpl_dw0_o,
    output reg [1:0] cpl_status_o
);

// ----------------------------------------------------------------------
// Reset synchroniser
// ----------------------------------------------------------------------
// Reset enters at once but leaves on the clock, so no flop of the block
// can see its release land between two clock edges
reg rst_meta_reg;
reg rst_sync_reg;
wire rst_n;

always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        rst_meta_reg <= 1'b0;
        rst_sync_reg <= 1'b0;
    end else begin
        rst_meta_reg <= 1'b1;
        rst_sync_reg <= rst_meta_reg;
    end
end

assign rst_n = rst_sync_reg;

// ----------------------------------------------------------------------
// Feature state
// ----------------------------------------------------------------------
localparam ST_IDLE = 2'h0;
localparam ST_XFER = 2'h1;
localparam ST_DONE = 2'h2;

reg [1:0] state_reg;
reg [7:0] fid_reg;
reg [31:0] dw11_reg;
// Packed arbitration settings: weights in 28:5, burst in 2:0; bits 4:3
// stay zero so that reserved attribute bits never come back on a get
reg [28:0] arb_reg;
reg [4:0] ps_reg;
reg [5:0] num_reg;
reg [4:0] supported_power_state_count_reg;
reg [9:0] bufptr_reg;
reg [9:0] xfer_ptr_reg;
reg busy_reg;
reg [31:0] dw0_reg;
reg [1:0] stat_reg;
reg xfer_pend_reg;
reg xfer_last_pend_reg;

wire cmd_go = reg_wr_i && (reg_addr_i == `FAH_REG_CMD) &&
              reg_wdata_i[`FAH_CMD_GO_BIT] && !busy_reg;
wire cmd_get = reg_wdata_i[`FAH_CMD_GET_BIT];
wire [7:0] cmd_fid = reg_wdata_i[7:0];

// Buffer access: software loads the structure word by word, xfer reads it
wire buf_wr = reg_wr_i && (reg_addr_i == `FAH_REG_BUFDATA) && !busy_reg;
wire buf_rd = reg_rd_i && (reg_addr_i == `FAH_REG_BUFDATA);

// Pointer value for the next cycle; the RAM is addressed with it one
// cycle early, so a data read finds the word even right after a load
reg [9:0] bufptr_next;

always @* begin
    bufptr_next = bufptr_reg;
    if (reg_wr_i && !busy_reg && (reg_addr_i == `FAH_REG_BUFPTR)) begin
        bufptr_next = reg_wdata_i[9:0];
    end else if (buf_wr || buf_rd) begin
        bufptr_next = bufptr_reg + 10'h001;
    end
end

wire [9:0] buf_rd_addr = (state_reg == ST_XFER) ? xfer_ptr_reg : bufptr_next;
wire [31:0] buf_rdata;

fah_range_buf u_buf (
    .clk_sys_i(clk_sys_i),
    .wr_en_i(buf_wr),
    .wr_addr_i(bufptr_reg),
    .wr_data_i(reg_wdata_i),
    .rd_addr_i(buf_rd_addr),
    .rd_data_o(buf_rdata)
);

// Word index of the first byte past the last entry in use
wire [10:0] used_words = {1'b0, num_reg, 4'h0} + 11'h010;
wire xfer_in_use = {1'b0, xfer_ptr_reg} < used_words;

// Assembled arbitration attribute word, reserved 07:03 as zero [RQ17]
wire [31:0] arb_word = {arb_reg[28:5], 5'h00, arb_reg[2:0]};

// ----------------------------------------------------------------------
// Command processing
// ----------------------------------------------------------------------
// A command is taken only while idle; register loads that arrive while
// a command runs are dropped, so the attribute word cannot change under
// the command that uses it
always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
        state_reg <= ST_IDLE;
        fid_reg <= 8'h00;
        dw11_reg <= 32'h0000_0000;
        arb_reg <= `FAH_ARB_RST;
        ps_reg <= `FAH_PS_RST;
        num_reg <= `FAH_NUM_RST;
        supported_power_state_count_reg <= `FAH_SUPPORTED_POWER_STATE_COUNT_RST;
        bufptr_reg <= 10'h000;
        xfer_ptr_reg <= 10'h000;
        busy_reg <= 1'b0;
        dw0_reg <= 32'h0000_0000;
        stat_reg <= `FAH_ST_OK;
        power_change_o <= 1'b0;
        cpl_valid_o <= 1'b0;
        cpl_dw0_o <= 32'h0000_0000;
        cpl_status_o <= `FAH_ST_OK;
        xfer_pend_reg <= 1'b0;
        xfer_last_pend_reg <= 1'b0;
    end else begin
        power_change_o <= 1'b0;
        cpl_valid_o <= 1'b0;
        xfer_pend_reg <= 1'b0;
        xfer_last_pend_reg <= 1'b0;
        if (reg_wr_i && !busy_reg) begin
            case (reg_addr_i)
                `FAH_REG_DW11: dw11_reg <= reg_wdata_i;
                `FAH_REG_SUPPORTED_POWER_STATE_COUNT: supported_power_state_count_reg <= reg_wdata_i[4:0];
                default: ;
            endcase
        end
        bufptr_reg <= bufptr_next;
        case (state_reg)
            ST_IDLE: begin
                if (cmd_go) begin
                    fid_reg <= cmd_fid;
                    busy_reg <= 1'b1;
                    stat_reg <= `FAH_ST_OK;
                    state_reg <= ST_DONE;
                    case (cmd_fid)
                        `FAH_FID_ARB: begin
                            if (cmd_get) begin
                                dw0_reg <= arb_word; // [RQ2]
                            end else begin
                                // Reserved 07:03 dropped on set [RQ1] [RQ17]
                                arb_reg <= {dw11_reg[31:8], 2'b00,
                                            dw11_reg[2:0]};
                                dw0_reg <= 32'h0000_0000;
                            end
                        end
                        `FAH_FID_PWR: begin
                            if (cmd_get) begin
                                dw0_reg <= {27'h0, ps_reg}; // [RQ2] [RQ17]
                            end else if (dw11_reg[4:0] > supported_power_state_count_reg) begin
                                // Unsupported state: refuse, keep old [RQ8]
                                stat_reg <= `FAH_ST_BADPS;
                                dw0_reg <= 32'h0000_0000;
                            end else begin
                                ps_reg <= dw11_reg[`FAH_PS_MSB:`FAH_PS_LSB];
                                power_change_o <= 1'b1; // [RQ7]
                                dw0_reg <= 32'h0000_0000;
                            end
                        end
                        `FAH_FID_RANGE: begin
                            if (cmd_get) begin
                                // Count in dw0, then stream buffer [RQ9] [RQ11]
                                dw0_reg <= {26'h0, num_reg}; // [RQ12]
                                xfer_ptr_reg <= 10'h000;
                                state_reg <= ST_XFER;
                            end else begin
                                num_reg <= dw11_reg[`FAH_NUM_MSB:`FAH_NUM_LSB];
                                dw0_reg <= 32'h0000_0000;
                            end
                        end
                        default: begin
                            stat_reg <= `FAH_ST_BADFID;
                            dw0_reg <= 32'h0000_0000;
                        end
                    endcase
                end
            end
            ST_XFER: begin
                // Whole 4096-byte structure, one word per cycle [RQ10] [RQ13]
                xfer_pend_reg <= 1'b1;
                xfer_last_pend_reg <= (xfer_ptr_reg == 10'h3ff);
                xfer_ptr_reg <= xfer_ptr_reg + 10'h001;
                if (xfer_ptr_reg == 10'h3ff) begin
                    state_reg <= ST_DONE;
                end
            end
            ST_DONE: begin
                if (!xfer_pend_reg) begin
                    cpl_valid_o <= 1'b1;
                    cpl_dw0_o <= dw0_reg;
                    cpl_status_o <= stat_reg;
                    busy_reg <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            end
            default: state_reg <= ST_IDLE;
        endcase
    end
end

// ----------------------------------------------------------------------
// Transfer data path
// ----------------------------------------------------------------------
// The RAM answers one cycle after the pointer, so valid, last and the
// blanking flag are held back by one stage to line up with its data
reg xfer_zero_reg;

always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
        xfer_zero_reg <= 1'b0;
        xfer_valid_o <= 1'b0;
        xfer_data_o <= 32'h0000_0000;
        xfer_last_o <= 1'b0;
    end else begin
        xfer_zero_reg <= !xfer_in_use;
        xfer_valid_o <= xfer_pend_reg;
        xfer_last_o <= xfer_last_pend_reg;
        // Entries past the count go out as zero [RQ15]
        xfer_data_o <= (xfer_pend_reg && !xfer_zero_reg) ? buf_rdata :
                       32'h0000_0000;
    end
end

// ----------------------------------------------------------------------
// Per-class command counts
// ----------------------------------------------------------------------
// Weights are zero-based, so each count is one bit wider than its field:
// a weight of ffh lets 256 commands of that class run in one round
wire [26:0] class_count;

genvar cls;
generate
    for (cls = 0; cls < 3; cls = cls + 1) begin : g_class
        // Class 0 is low, 1 medium, 2 high, matching their field order
        assign class_count[cls*9 +: 9] =
            {1'b0, arb_reg[cls*8+5 +: 8]} + 9'h001; // [RQ3] [RQ4] [RQ5]
    end
endgenerate

// ----------------------------------------------------------------------
// Settings outputs, updated whenever any command completes
// ----------------------------------------------------------------------
always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
        high_class_count_o <= 9'h001;
        medium_class_count_o <= 9'h001;
        low_class_count_o <= 9'h001;
        queue_burst_limit_o <= 3'h0;
        burst_unlimited_o <= 1'b0;
        power_state_select_o <= `FAH_PS_RST;
    end else if (state_reg == ST_DONE && !xfer_pend_reg) begin
        // New values reach the arbiter with the completion [RQ16]
        high_class_count_o <= class_count[26:18]; // [RQ3]
        medium_class_count_o <= class_count[17:9]; // [RQ4]
        low_class_count_o <= class_count[8:0]; // [RQ5]
        queue_burst_limit_o <= arb_reg[2:0]; // [RQ6]
        burst_unlimited_o <= (arb_reg[2:0] == `FAH_BURST_NOLIMIT); // [RQ6]
        power_state_select_o <= ps_reg; // [RQ7]
    end
end

// ----------------------------------------------------------------------
// Register read port
// ----------------------------------------------------------------------
// Decodes the live address; the flop below turns it into read data
reg [31:0] rd_mux;

always @* begin
    case (reg_addr_i)
        `FAH_REG_CMD: rd_mux = {23'h0, busy_reg, fid_reg};
        `FAH_REG_DW11: rd_mux = dw11_reg;
        `FAH_REG_STATUS: rd_mux = {29'h0, busy_reg, stat_reg};
        `FAH_REG_DW0: rd_mux = dw0_reg;
        `FAH_REG_ARB: rd_mux = arb_word;
        `FAH_REG_PWR: rd_mux = {27'h0, ps_reg};
        `FAH_REG_SUPPORTED_POWER_STATE_COUNT: rd_mux = {27'h0, supported_power_state_count_reg};
        `FAH_REG_BUFPTR: rd_mux = {22'h0, bufptr_reg};
        `FAH_REG_BUFDATA: rd_mux = buf_rdata;
        default: rd_mux = 32'h0000_0000;
    endcase
end

// Read data stand for exactly one cycle after the strobe and are zero
// otherwise, so a stale word is never mistaken for an answer
always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
        reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
        reg_rdata_o <= rd_mux;
    end else begin
        reg_rdata_o <= 32'h0000_0000;
    end
end

endmodule // fah_feature_handler

//--- hdl/fah_map.vh
// Constants for the feature attribute handler: ids, fields, resets, registers, status codes
`ifndef FAH_MAP_VH
`define FAH_MAP_VH

// Feature identifiers
`define FAH_FID_ARB 8'h01
`define FAH_FID_PWR 8'h02
`define FAH_FID_RANGE 8'h03

// Arbitration attribute fields
`define FAH_HPW_MSB 31
`define FAH_HPW_LSB 24
`define FAH_MPW_MSB 23
`define FAH_MPW_LSB 16
`define FAH_LPW_MSB 15
`define FAH_LPW_LSB 8
`define FAH_BURST_MSB 2
`define FAH_BURST_LSB 0
`define FAH_BURST_NOLIMIT 3'h7

// Power and range attribute fields
`define FAH_PS_MSB 4
`define FAH_PS_LSB 0
`define FAH_NUM_MSB 5
`define FAH_NUM_LSB 0

// Range buffer geometry
`define FAH_RANGE_BYTES 13'h1000
`define FAH_ENTRY_BYTES 7'h40
`define FAH_MAX_ENTRIES 7'h40
`define FAH_BUF_WORDS 11'h400

// Reset values
`define FAH_ARB_RST 29'h0000_0000
`define FAH_PS_RST 5'h00
`define FAH_NUM_RST 6'h00
`define FAH_SUPPORTED_POWER_STATE_COUNT_RST 5'h00

// Register offsets (word addresses)
`define FAH_REG_CMD 4'h0
`define FAH_REG_DW11 4'h1
`define FAH_REG_STATUS 4'h2
`define FAH_REG_DW0 4'h3
`define FAH_REG_ARB 4'h4
`define FAH_REG_PWR 4'h5
`define FAH_REG_SUPPORTED_POWER_STATE_COUNT 4'h6
`define FAH_REG_BUFPTR 4'h7
`define FAH_REG_BUFDATA 4'h8

// Command register fields
`define FAH_CMD_GO_BIT 8
`define FAH_CMD_GET_BIT 9

// Status codes placed in the status register
`define FAH_ST_OK 2'h0
`define FAH_ST_BADFID 2'h1
`define FAH_ST_BADPS 2'h2

`endif

//--- hdl/fah_range_buf.v
// Range description buffer: 1024 words of 32 bits, one write and one read
`timescale 1ns/1ps

module fah_range_buf (
    // Clock
    input wire clk_sys_i,
    // Write side
    input wire wr_en_i,
    input wire [9:0] wr_addr_i,
    input wire [31:0] wr_data_i,
    // Read side
    input wire [9:0] rd_addr_i,
    output reg [31:0] rd_data_o
);

reg [31:0] mem [0:1023];

// Synchronous read; contents are not reset to keep it a plain RAM
always @(posedge clk_sys_i) begin
    if (wr_en_i) begin
        mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
end

endmodule // fah_range_buf

//--- verif/fah_feature_props.sv
// Checker of feature completions, settings and range stream
`timescale 1ns/1ps
`include "fah_map.vh"
module fah_feature_props (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // Register port
    input wire [3:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    // Settings
    input wire [8:0] high_class_count_o,
    input wire [8:0] medium_class_count_o,
    input wire [8:0] low_class_count_o,
    input wire [2:0] queue_burst_limit_o,
    input wire burst_unlimited_o,
    input wire [4:0] power_state_select_o,
    // Stream and completion
    input wire xfer_valid_o,
    input wire [31:0] xfer_data_o,
    input wire xfer_last_o,
    input wire cpl_valid_o,
    input wire [31:0] cpl_dw0_o,
    input wire [1:0] cpl_status_o
);
    reg [7:0] fid_reg;
    reg get_reg;
    reg [31:0] dw11_reg;
    reg [4:0] supported_power_state_count_reg;
    reg [5:0] num_reg;
    reg [10:0] xcnt_reg;
    wire cmd_wr = reg_wr_i && reg_addr_i == `FAH_REG_CMD && reg_wdata_i[8];
    wire cpl_of = cpl_valid_o && fid_reg == `FAH_FID_ARB && get_reg;
    wire pwr_set = cpl_valid_o && fid_reg == `FAH_FID_PWR && !get_reg;
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fid_reg <= 8'h00;
            get_reg <= 1'b0;
            dw11_reg <= 32'h0;
            supported_power_state_count_reg <= 5'h00;
            num_reg <= 6'h00;
            xcnt_reg <= 11'h000;
        end else begin
            if (reg_wr_i && reg_addr_i == `FAH_REG_DW11)
                dw11_reg <= reg_wdata_i;
            if (reg_wr_i && reg_addr_i == `FAH_REG_SUPPORTED_POWER_STATE_COUNT)
                supported_power_state_count_reg <= reg_wdata_i[4:0];
            if (cmd_wr) begin
                fid_reg <= reg_wdata_i[7:0];
                get_reg <= reg_wdata_i[9];
            end
            if (cpl_valid_o && fid_reg == `FAH_FID_RANGE && !get_reg)
                num_reg <= dw11_reg[5:0];
            xcnt_reg <= xfer_valid_o ? xcnt_reg + 11'h001 : 11'h000;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    a_cmd_answer: assert property (
        cmd_wr && reg_wdata_i[9:0] != 10'h303
        |-> ##2 cpl_valid_o) else $error("completion late");
    a_stream_start: assert property (
        cmd_wr && reg_wdata_i[9:0] == 10'h303
        |-> ##3 xfer_valid_o) else $error("range stream late");
    a_last_index: assert property (xfer_last_o
        |-> xfer_valid_o
        && xcnt_reg == 11'h3ff ##[1:2] cpl_valid_o) else $error("bad last");
    a_unused_zero: assert property (xfer_valid_o
        && xcnt_reg >= ({5'h00, num_reg} + 11'h001) * 11'h010
        |-> xfer_data_o == 32'h0) else $error("unused entry not zero");
    a_range_count: assert property (cpl_valid_o && get_reg
        && fid_reg == `FAH_FID_RANGE |-> cpl_dw0_o == {26'h0, num_reg})
        else $error("range count wrong");
    a_high_weight: assert property (cpl_of |-> high_class_count_o
        == {1'b0, cpl_dw0_o[31:24]} + 9'h001) else $error("high count");
    a_medium_weight: assert property (cpl_of |-> medium_class_count_o
        == {1'b0, cpl_dw0_o[23:16]} + 9'h001) else $error("medium count");
    a_low_weight: assert property (cpl_of |-> low_class_count_o
        == {1'b0, cpl_dw0_o[15:8]} + 9'h001) else $error("low count");
    a_burst_field: assert property (cpl_of
        |-> cpl_dw0_o[7:3] == 5'h00
        && queue_burst_limit_o == cpl_dw0_o[2:0]) else $error("burst field");
    a_burst_none: assert property (burst_unlimited_o ==
        (queue_burst_limit_o == 3'h7)) else $error("unlimited flag");
    a_power_move: assert property (pwr_set
        && dw11_reg[4:0] <= supported_power_state_count_reg
        |-> cpl_status_o == `FAH_ST_OK ##1 power_state_select_o
        == dw11_reg[4:0]) else $error("power state not taken");
    a_power_refuse: assert property (pwr_set
        && dw11_reg[4:0] > supported_power_state_count_reg |-> cpl_status_o == `FAH_ST_BADPS
        && power_state_select_o == $past(power_state_select_o, 2))
        else $error("bad power state taken");
    a_bad_feature: assert property (cpl_valid_o && (fid_reg == 8'h00
        || fid_reg > 8'h03) |-> cpl_status_o == `FAH_ST_BADFID)
        else $error("bad feature accepted");
    c_arb_get: cover property (cpl_of);
    c_range_end: cover property (xfer_last_o);
    c_power_refuse: cover property (cpl_valid_o && cpl_status_o == 2'h2);
endmodule // fah_feature_props
bind fah_feature_handler fah_feature_props u_fah_feature_props (
    .clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .high_class_count_o, .medium_class_count_o, .low_class_count_o,
    .queue_burst_limit_o, .burst_unlimited_o, .power_state_select_o,
    .xfer_valid_o, .xfer_data_o, .xfer_last_o, .cpl_valid_o,
    .cpl_dw0_o, .cpl_status_o);

//--- verif/fah_host_sink.sv
// Host data buffer model that tallies the range stream
`timescale 1ns/1ps
module fah_host_sink (
    // Clock
    input wire clk_sys_i,
    // Range stream
    input wire xfer_valid_i,
    input wire [31:0] xfer_data_i,
    input wire xfer_last_i,
    // Tallies for the bench
    output reg [11:0] words_o,
    output reg [11:0] nonzero_o,
    output reg [11:0] last_at_o
);
    initial begin
        words_o = 12'h000;
        nonzero_o = 12'h000;
        last_at_o = 12'h000;
    end
    // One flat 4096-byte region, so words simply land in order
    always @(posedge clk_sys_i) begin
        if (xfer_valid_i === 1'b1) begin
            words_o <= words_o + 12'h001;
            if (xfer_data_i !== 32'h0)
                nonzero_o <= nonzero_o + 12'h001;
            if (xfer_last_i === 1'b1)
                last_at_o <= words_o;
        end
    end
endmodule // fah_host_sink

//--- verif/fah_feature_handler_bench.sv
// Bench for the feature set/get handler
`timescale 1ns/1ps
`include "fah_map.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module fah_feature_handler_bench;
    reg clk_sys_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg [3:0] reg_addr_i = 4'h0;
    reg [31:0] reg_wdata_i = 32'h0;
    reg reg_wr_i = 1'b0;
    reg reg_rd_i = 1'b0;
    wire [31:0] reg_rdata_o, xfer_data_o, cpl_dw0_o;
    wire [8:0] high_class_count_o, medium_class_count_o, low_class_count_o;
    wire [2:0] queue_burst_limit_o;
    wire [4:0] power_state_select_o;
    wire [1:0] cpl_status_o;
    wire burst_unlimited_o, power_change_o, xfer_valid_o, xfer_last_o;
    wire cpl_valid_o;
    wire [11:0] words, nonzero, last_at;
    logic [11:0] w;
    logic [11:0] z;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    int pchg = 0;
    int p;
    fah_feature_handler u_fah_feature_handler (.clk_sys_i, .rst_n_i,
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .high_class_count_o, .medium_class_count_o, .low_class_count_o,
        .queue_burst_limit_o, .burst_unlimited_o, .power_state_select_o,
        .power_change_o, .xfer_valid_o, .xfer_data_o, .xfer_last_o,
        .cpl_valid_o, .cpl_dw0_o, .cpl_status_o);
    fah_host_sink u_fah_host_sink (.clk_sys_i, .xfer_valid_i(xfer_valid_o),
        .xfer_data_i(xfer_data_o), .xfer_last_i(xfer_last_o),
        .words_o(words), .nonzero_o(nonzero), .last_at_o(last_at));
    always #2.5 clk_sys_i = ~clk_sys_i;
    // ----
    // Watchdog and power pulse tally
    // ----
    always @(posedge clk_sys_i) begin
        cyc++;
        if (power_change_o === 1'b1)
            pchg++;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end
    task stop_test;
        $display("Checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task wr(input [3:0] a, input [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task rd(input [3:0] a, input [31:0] e);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 `CHK(reg_rdata_o, e)
    endtask
    // Settings are looked at one cycle after the completion pulse
    task cmd(input [7:0] f, input g, input [31:0] d, input [1:0] st,
        input [31:0] dw0);
        int n;
        wr(`FAH_REG_DW11, d);
        wr(`FAH_REG_CMD, {22'h0, g, 1'b1, f});
        n = 0;
        #1;
        while (cpl_valid_o !== 1'b1 && n < 2000) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        `CHK(cpl_valid_o, 1'b1)
        `CHK(cpl_status_o, st)
        if (g)
            `CHK(cpl_dw0_o, dw0)
        @(posedge clk_sys_i);
        #1;
        `CHK(cpl_valid_o, 1'b0)
    endtask
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1 `CHK(high_class_count_o, 9'h001)
        `CHK(power_state_select_o, 5'h00)
        cmd(`FAH_FID_ARB, 1'b0, 32'hfe7f00fb,
            `FAH_ST_OK, 0);
        `CHK(high_class_count_o, 9'h0ff)
        `CHK(medium_class_count_o, 9'h080)
        `CHK(low_class_count_o, 9'h001)
        cmd(`FAH_FID_ARB, 1'b1, 0, `FAH_ST_OK, 32'hfe7f0003);
        rd(`FAH_REG_ARB, 32'hfe7f0003);
        for (int i = 0; i < 8; i++) begin
            cmd(`FAH_FID_ARB, 1'b0, {29'h0, i[2:0]}, `FAH_ST_OK, 0);
            `CHK(queue_burst_limit_o, i[2:0])
            `CHK(burst_unlimited_o, i == 7)
        end
        wr(`FAH_REG_SUPPORTED_POWER_STATE_COUNT, 32'h3);
        rd(`FAH_REG_SUPPORTED_POWER_STATE_COUNT, 32'h3);
        p = pchg;
        cmd(`FAH_FID_PWR, 1'b0, 32'hffffffe3,
            `FAH_ST_OK, 0);
        `CHK(power_state_select_o, 5'h03)
        cmd(`FAH_FID_PWR, 1'b1, 0, `FAH_ST_OK, 32'h3);
        cmd(`FAH_FID_PWR, 1'b0, 32'h4, `FAH_ST_BADPS, 0);
        `CHK(power_state_select_o, 5'h03)
        `CHK(pchg, p + 1)
        cmd(8'h04, 1'b0, 0, `FAH_ST_BADFID, 0);
        // Entry 0 in use and a stale entry 1 that must come back blank
        wr(`FAH_REG_BUFPTR, 32'h0);
        for (int i = 0; i < 32; i++)
            wr(`FAH_REG_BUFDATA, 32'ha5000000 + i);
        cmd(`FAH_FID_RANGE, 1'b0, 32'hffffffc0,
            `FAH_ST_OK, 0);
        w = words;
        z = nonzero;
        cmd(`FAH_FID_RANGE, 1'b1, 0, `FAH_ST_OK, 32'h0);
        `CHK(words - w, 12'h400)
        `CHK(nonzero - z, 12'h010)
        `CHK(last_at - w, 12'h3ff)
        stop_test();
    end
endmodule // fah_feature_handler_bench
